/* File: hdl/ccr_pkg.sv */
/*
  Package for the codec control register bank (registers one and two).
  Holds the frame word layout, register codes, bit positions and reset values.
  Assumes nothing of its surroundings.
*/
package ccr_pkg;

  // ----------------------------------------
  // Control frame word layout
  // ----------------------------------------
  localparam int CCR_WORD_W   = 16;          // Control word width
  localparam int CCR_ADDR_HI  = 15;          // Register address top bit
  localparam int CCR_ADDR_LO  = 13;          // Register address low bit
  localparam int CCR_RW_BIT   = 12;          // Read flag, 0 means write
  localparam int CCR_DATA_W   = 8;           // Register content width

  // Register address codes
  localparam logic [2:0] CCR_ADDR_ONE = 3'h1; // First control register
  localparam logic [2:0] CCR_ADDR_TWO = 3'h2; // Second control register

  // ----------------------------------------
  // Register one fields
  // ----------------------------------------
  localparam int CCR_B_ADC_OVR   = 7;        // ADC overflow flag, read only
  localparam int CCR_B_CONT      = 6;        // Continuous transfer select
  localparam int CCR_B_RECURSIVE = 5;        // Recursive filter select
  localparam int CCR_B_DAC_OVR   = 4;        // DAC overflow flag, read only
  localparam int CCR_B_BIAS      = 3;        // Bias level select
  localparam int CCR_B_ALOOP     = 2;        // Analog loopback enable
  localparam int CCR_B_DLOOP     = 1;        // Digital loopback enable
  localparam int CCR_B_FULL_DAC  = 0;        // Full width DAC word
  localparam logic [7:0] CCR_ONE_RESET = 8'h00; // Register one reset value
  localparam logic [7:0] CCR_ONE_WMASK = 8'h6f; // Writable bits of register one

  // ----------------------------------------
  // Register two fields
  // ----------------------------------------
  localparam int CCR_B_TURBO   = 7;          // Bit clock turbo select
  localparam int CCR_B_BYPASS  = 6;          // Rate filter bypass
  localparam int CCR_B_SADR_HI = 5;          // Serial address upper bits top
  localparam int CCR_B_SADR_LO = 3;          // Serial address upper bits bottom
  localparam int CCR_B_SPARE   = 2;          // Spare output bit
  localparam int CCR_B_PINCFG_HI = 1;        // Host pin config top
  localparam int CCR_B_PINCFG_LO = 0;        // Host pin config bottom
  localparam logic [7:0] CCR_TWO_RESET    = 8'h20; // Address bits reset to 100
  localparam logic [1:0] CCR_PINCFG_SPARE = 2'h2;  // Data pin follows spare output

  // ----------------------------------------
  // Bit clock and address
  // ----------------------------------------
  localparam int CCR_BITS_PER_SLOT = 16;     // Bit clocks per slot
  localparam logic [3:0] CCR_DEV_CODE = 4'h5; // Fixed device code, arbitrary value
  localparam int CCR_CNT_W = 12;             // Bit clock divider counter width

endpackage : ccr_pkg

/* File: hdl/ccr_cfg_if.sv */
/*
  Interface carrying the committed configuration from the register bank
  to the bit clock generator. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface ccr_cfg_if;
  logic       turbo;        // Turbo bit clock select
  logic       cont_mode;    // Continuous transfer active
  logic [3:0] n_devices;    // Number of cascaded devices
  logic [7:0] div_p;        // Master clock divider value
  logic       sclk;         // Generated bit clock level
  logic       sclk_rise;    // One cycle rising edge pulse

  modport bank (output turbo, cont_mode, n_devices, div_p, input sclk, sclk_rise);
  modport gen  (input turbo, cont_mode, n_devices, div_p, output sclk, sclk_rise);
endinterface : ccr_cfg_if
`default_nettype wire

/* File: hdl/ccr_sclk_gen.sv */
/*
  Bit clock generator for the codec control bank.
  Normal mode: period derived from frame rate, device count and mode factor.
  Turbo mode: master clock divided by P. Assumes clk_i is the master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_sclk_gen
  import ccr_pkg::*;
#(
  parameter int FRAME_DIV = 1024            // Master clocks per frame period
) (
  input  wire logic clk_i,                  // Master clock
  input  wire logic reset_n_i,              // Asynchronous reset, active low
  ccr_cfg_if.gen    cfg                     // Configuration and bit clock
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [CCR_CNT_W-1:0] cnt;              // Half period counter
    logic                 sclk;             // Clock level
    logic                 rise;             // Rising edge pulse
  } ccr_gen_t;

  ccr_gen_t st_r;                           // Registered state
  ccr_gen_t st_nxt;                         // Next state
  logic [CCR_CNT_W-1:0] half_w;             // Half period in master clocks
  logic [CCR_CNT_W-1:0] bits_w;             // Bit clocks per frame

  // Half period selection
  always_comb begin
    // R10 normal rate formula
    bits_w = CCR_CNT_W'(CCR_BITS_PER_SLOT) * CCR_CNT_W'(cfg.n_devices)
             * (cfg.cont_mode ? CCR_CNT_W'(1) : CCR_CNT_W'(2));
    if (cfg.turbo) begin
      // R11 turbo divides by P
      half_w = CCR_CNT_W'(cfg.div_p) >> 1;
    end else if (bits_w != '0) begin
      half_w = CCR_CNT_W'(FRAME_DIV) / (bits_w << 1);
    end else begin
      half_w = CCR_CNT_W'(1);
    end
    if (half_w == '0) begin
      half_w = CCR_CNT_W'(1);
    end
  end

  // Counter toggles the clock each half period
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rise = 1'b0;
    if (st_r.cnt + CCR_CNT_W'(1) >= half_w) begin
      st_nxt.cnt  = '0;
      st_nxt.sclk = ~st_r.sclk;
      st_nxt.rise = ~st_r.sclk;
    end else begin
      st_nxt.cnt = st_r.cnt + CCR_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.sclk      = st_r.sclk;
  assign cfg.sclk_rise = st_r.rise;

  // a_rise_pulse: rise pulse matches clock going high
  a_rise_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
    cfg.sclk_rise |-> cfg.sclk && !$past(cfg.sclk))
    else $error("Rise pulse without clock edge");

endmodule : ccr_sclk_gen
`default_nettype wire

/* File: hdl/ccr_regs.sv */
/*
  Codec control register bank: control registers one and two.
  Control frame words arrive on a parallel word strobe already deserialised;
  reads answer on rd_data_o in the same frame. Assumes overflow events,
  frame sync and the DAC continuous-mode word are synchronous to clk_i.
*/
// What this block does
// R1 - Bit 7 reg one reports ADC overflow
// R2 - Bit 6 reg one selects continuous transfer
// R3 - Bit 5 reg one selects recursive filter
// R4 - Bit 4 reg one reports DAC overflow
// R5 - Bit 3 reg one drives bias select
// R6 - Bit 2 reg one enables analog loopback
// R7 - Bit 1 reg one enables digital loopback
// R8 - Bit 0 selects DAC word length
// R9 - DAC word LSB set returns to programming; code does this only while reg one bit 0 is clear
// R10 - Turbo low: bit clock from frame rate
// R11 - Turbo high: bit clock is master/P
// R12 - Bit 6 reg two bypasses rate filters
// R13 - Bits 5-3 form serial address, reset 100
// R14 - Spare output drives data pin when 10
// R15 - Bits 1-0 select host pin config
// R16 - Word: address top, read flag, low data
// R17 - Writes take effect one frame later
// R18 - Codes 001 and 010 select registers
// R19 - Other codes normal; flag writes ignored
`timescale 1ns/1ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int         FRAME_DIV = 1024,   // Master clocks per frame
  parameter logic [3:0] N_DEVICES = 4'h1,   // Cascaded devices
  parameter logic [7:0] DIV_P     = 8'h08   // Master clock divider P
) (
  input  wire logic                  clk_i,            // Master clock
  input  wire logic                  reset_n_i,        // Async reset, active low
  input  wire logic                  word_valid_i,     // Control word strobe
  input  wire logic [CCR_WORD_W-1:0] word_i,           // Control frame word
  input  wire logic                  frame_sync_i,     // Frame sync pulse
  input  wire logic                  dac_word_valid_i, // DAC data word strobe
  input  wire logic [CCR_WORD_W-1:0] dac_word_i,       // DAC data word
  input  wire logic                  adc_ovf_i,        // ADC overflow event
  input  wire logic                  dac_ovf_i,        // DAC overflow event
  input  wire logic                  sda_ctl_o_i,      // Two-wire data out, normal
  input  wire logic                  sda_ctl_oe_n_i,   // Two-wire data enable, normal
  output logic [CCR_DATA_W-1:0]      rd_data_o,        // Read answer byte
  output logic                       rd_valid_o,       // Read answer strobe
  output logic                       continuous_transfer_select_o, // Continuous mode
  output logic                       recursive_filter_select_o,    // Filter type
  output logic                       bias_level_select_o,          // Bias select
  output logic                       analog_loop_enable_o,         // Analog loop
  output logic                       digital_loop_enable_o,        // Digital loop
  output logic                       full_width_dac_word_o,        // DAC word width
  output logic                       rate_filter_bypass_o,         // Filter bypass
  output logic [6:0]                 serial_address_o,             // Two-wire address
  output logic [1:0]                 host_pin_config_o,            // Host pin config
  output logic                       sclk_o,                       // Bit clock
  output logic                       sda_o,                        // Data pin value
  output logic                       sda_oe_n_o                    // Data pin enable, low
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pend_one;                   // Written, not yet active, reg one
    logic [7:0] pend_two;                   // Written, not yet active, reg two
    logic [7:0] act_one;                    // Active reg one (writable part)
    logic [7:0] act_two;                    // Active reg two
    logic       adc_ovf;                    // ADC overflow flag
    logic       dac_ovf;                    // DAC overflow flag
    logic [7:0] rd_data;                    // Read answer
    logic       rd_valid;                   // Read answer strobe
    logic       sda;                        // Data pin value
    logic       sda_oe_n;                   // Data pin enable
    logic       sclk;                       // Bit clock copy
  } ccr_regs_t;

  ccr_regs_t st_r;                          // Registered state
  ccr_regs_t st_nxt;                        // Next state
  logic [2:0] addr_w;                       // Decoded address
  logic       is_read_w;                    // Read flag
  logic [7:0] data_w;                       // Word content
  logic [7:0] view_one_w;                   // Register one as read back

  ccr_cfg_if cfg ();                        // Link to bit clock generator

  // ----------------------------------------
  // Bit clock generator
  // ----------------------------------------
  ccr_sclk_gen #(
    .FRAME_DIV (FRAME_DIV)
  ) u_sclk (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cfg       (cfg)
  );

  assign cfg.turbo     = st_r.act_two[CCR_B_TURBO];
  assign cfg.cont_mode = st_r.act_one[CCR_B_CONT];
  assign cfg.n_devices = N_DEVICES;
  assign cfg.div_p     = DIV_P;

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  // R16 field split of control word
  assign addr_w    = word_i[CCR_ADDR_HI:CCR_ADDR_LO];
  assign is_read_w = word_i[CCR_RW_BIT];
  assign data_w    = word_i[CCR_DATA_W-1:0];

  // Read view merges the two flags into register one
  always_comb begin
    view_one_w = st_r.act_one & CCR_ONE_WMASK;
    // R1 ADC flag readback
    view_one_w[CCR_B_ADC_OVR] = st_r.adc_ovf;
    // R4 DAC flag readback
    view_one_w[CCR_B_DAC_OVR] = st_r.dac_ovf;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.sclk     = cfg.sclk;

    // Overflow flags follow their event levels
    st_nxt.adc_ovf = adc_ovf_i;
    st_nxt.dac_ovf = dac_ovf_i;

    // R17 commit pending values at frame sync
    if (frame_sync_i) begin
      st_nxt.act_one = st_r.pend_one;
      st_nxt.act_two = st_r.pend_two;
    end

    // Control words only accepted in programming mode
    if (word_valid_i && !st_r.act_one[CCR_B_CONT]) begin
      if (is_read_w) begin
        st_nxt.rd_valid = 1'b1;
        // R18 register code decode for read
        case (addr_w)
          CCR_ADDR_ONE: st_nxt.rd_data = view_one_w;
          CCR_ADDR_TWO: st_nxt.rd_data = st_r.act_two;
          default:      st_nxt.rd_data = 8'h00;
        endcase
      end else begin
        // R18 register code decode for write
        case (addr_w)
          CCR_ADDR_ONE: begin
            // R19 flag bits not writable
            st_nxt.pend_one = data_w & CCR_ONE_WMASK;
          end
          CCR_ADDR_TWO: begin
            st_nxt.pend_two = data_w;
          end
          default: begin
            st_nxt.pend_one = st_nxt.pend_one;
          end
        endcase
      end
    end

    // R9 flagged DAC word leaves continuous mode
    if (dac_word_valid_i && st_r.act_one[CCR_B_CONT]
        && !st_r.act_one[CCR_B_FULL_DAC] && dac_word_i[0]) begin
      st_nxt.act_one[CCR_B_CONT]  = 1'b0;
      st_nxt.pend_one[CCR_B_CONT] = 1'b0;
    end

    // R14 spare output drives data pin
    if (st_r.act_two[CCR_B_PINCFG_HI:CCR_B_PINCFG_LO] == CCR_PINCFG_SPARE) begin
      st_nxt.sda      = st_r.act_two[CCR_B_SPARE];
      st_nxt.sda_oe_n = 1'b0;
    end else begin
      // R19 normal two-wire control
      st_nxt.sda      = sda_ctl_o_i;
      st_nxt.sda_oe_n = sda_ctl_oe_n_i;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r          <= '0;
      st_r.pend_one <= CCR_ONE_RESET;
      st_r.act_one  <= CCR_ONE_RESET;
      st_r.pend_two <= CCR_TWO_RESET;
      st_r.act_two  <= CCR_TWO_RESET;
      st_r.sda_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops except the fixed device code bits of serial_address_o
  // ----------------------------------------
  assign rd_data_o                    = st_r.rd_data;
  assign rd_valid_o                   = st_r.rd_valid;
  // R2 continuous transfer select
  assign continuous_transfer_select_o = st_r.act_one[CCR_B_CONT];
  // R3 filter type select
  assign recursive_filter_select_o    = st_r.act_one[CCR_B_RECURSIVE];
  // R5 bias select output
  assign bias_level_select_o          = st_r.act_one[CCR_B_BIAS];
  // R6 analog loopback output
  assign analog_loop_enable_o         = st_r.act_one[CCR_B_ALOOP];
  // R7 digital loopback output
  assign digital_loop_enable_o        = st_r.act_one[CCR_B_DLOOP];
  // R8 DAC word width output
  assign full_width_dac_word_o        = st_r.act_one[CCR_B_FULL_DAC];
  // R12 filter bypass output
  assign rate_filter_bypass_o         = st_r.act_two[CCR_B_BYPASS];
  // R13 address from upper bits and device code
  assign serial_address_o             = {st_r.act_two[CCR_B_SADR_HI:CCR_B_SADR_LO], CCR_DEV_CODE};
  // R15 host pin config output
  assign host_pin_config_o            = st_r.act_two[CCR_B_PINCFG_HI:CCR_B_PINCFG_LO];
  assign sclk_o                       = st_r.sclk;
  assign sda_o                        = st_r.sda;
  assign sda_oe_n_o                   = st_r.sda_oe_n;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_adc_flag_track: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    rd_valid_o && $past(word_i[15:13]) == CCR_ADDR_ONE |-> rd_data_o[7] == $past(st_r.adc_ovf))
    else $error("ADC flag readback wrong");
  a_dac_flag_track: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    rd_valid_o && $past(word_i[15:13]) == CCR_ADDR_ONE |-> rd_data_o[4] == $past(st_r.dac_ovf))
    else $error("DAC flag readback wrong");
  a_write_delayed: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    !frame_sync_i && !(dac_word_valid_i && continuous_transfer_select_o)
      |=> $stable(continuous_transfer_select_o))
    else $error("Config changed without frame sync");
  a_commit_two: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    frame_sync_i |=> st_r.act_two == $past(st_r.pend_two))
    else $error("Register two not committed at frame sync");
  a_flag_write_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R19
    word_valid_i && !is_read_w && addr_w == CCR_ADDR_ONE && !continuous_transfer_select_o
      |=> st_r.pend_one[7] == 1'b0 && st_r.pend_one[4] == 1'b0)
    else $error("Flag bits were written");
  a_exit_cont: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
    dac_word_valid_i && continuous_transfer_select_o && !full_width_dac_word_o && dac_word_i[0]
      |=> !continuous_transfer_select_o)
    else $error("Flagged DAC word did not leave continuous mode");
  a_spare_pin: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    host_pin_config_o == CCR_PINCFG_SPARE ##1 host_pin_config_o == CCR_PINCFG_SPARE
      |-> !sda_oe_n_o && sda_o == $past(st_r.act_two[CCR_B_SPARE]))
    else $error("Data pin not following spare output");
  a_addr_form: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    serial_address_o[3:0] == CCR_DEV_CODE)
    else $error("Device code missing from address");
  a_read_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    word_valid_i && is_read_w && !continuous_transfer_select_o |=> rd_valid_o)
    else $error("Read not answered");

  c_read_one:   cover property (@(posedge clk_i) rd_valid_o && rd_data_o[7]);
  c_enter_cont: cover property (@(posedge clk_i) $rose(continuous_transfer_select_o));
  c_exit_cont:  cover property (@(posedge clk_i) $fell(continuous_transfer_select_o));
  c_spare_mode: cover property (@(posedge clk_i) host_pin_config_o == CCR_PINCFG_SPARE);

endmodule : ccr_regs
`default_nettype wire

/* File: verif/ccr_host_model.sv */
/*
  Host DSP model: sends control frame words, frame sync and DAC words.
  Assumes one clock; drives on the falling edge, samples answers there too.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model
  import ccr_pkg::*;
(
  input  wire logic                  clk_i,            // Master clock
  input  wire logic                  rd_valid_i,       // Read answer strobe
  input  wire logic [CCR_DATA_W-1:0] rd_data_i,        // Read answer byte
  output logic                       word_valid_o,     // Control word strobe
  output logic [CCR_WORD_W-1:0]      word_o,           // Control word
  output logic                       frame_sync_o,     // Frame sync pulse
  output logic                       dac_word_valid_o, // DAC word strobe
  output logic [CCR_WORD_W-1:0]      dac_word_o        // DAC word
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  initial begin
    word_valid_o     = 1'b0;
    word_o           = 16'hffff;
    frame_sync_o     = 1'b0;
    dac_word_valid_o = 1'b0;
    dac_word_o       = 16'hffff;
  end

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // word layout and codes
  task automatic send(input logic [2:0] code, input logic rd, input logic [7:0] data);
    @(negedge clk_i);
    word_o       <= {code, rd, 4'h0, data};
    word_valid_o <= 1'b1;
    @(negedge clk_i);
    word_valid_o <= 1'b0;
    word_o       <= ~word_o;     // Released word no longer shows old value
  endtask : send

  // Read with a bounded wait for the answer strobe
  task automatic read(input logic [2:0] code, output logic [7:0] data, output logic ok);
    int n;
    ok   = 1'b0;
    data = 8'h00;
    send(code, 1'b1, 8'h00);
    for (n = 0; n < 3 && !ok; n++) begin
      if (rd_valid_i === 1'b1) begin
        ok   = 1'b1;
        data = rd_data_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : read

  // Frame sync pulse, then let the commit land
  task automatic fsync();
    @(negedge clk_i);
    frame_sync_o <= 1'b1;
    @(negedge clk_i);
    frame_sync_o <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : fsync

  // host may set the word LSB
  task automatic dac(input logic [15:0] w);
    @(negedge clk_i);
    dac_word_o       <= w;
    dac_word_valid_o <= 1'b1;
    @(negedge clk_i);
    dac_word_valid_o <= 1'b0;
    dac_word_o       <= ~w;
    @(negedge clk_i);
  endtask : dac
endmodule : ccr_host_model
`default_nettype wire

/* File: verif/tb_top.sv */
/*
  Self-checking testbench for the codec control register bank.
  Assumes the host model drives control traffic; bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccr_pkg::*;
;
  logic        clk_i = 1'b0;          // Master clock
  logic        reset_n = 1'b0;        // Reset, active low
  logic        adc_ovf = 1'b0;        // ADC overflow level
  logic        dac_ovf = 1'b0;        // DAC overflow level
  logic        sda_ctl = 1'b1;        // Normal data pin value
  logic        sda_ctl_oe_n = 1'b0;   // Normal data pin enable, low
  logic        wv, fsy, dv, rv;       // Strobes
  logic [15:0] w, dw;                 // Words
  logic [7:0]  rd, d;                 // Read data
  logic        ok;                    // Answer seen
  logic        cont, recf, bias, aloop, dloop, d16, byp, sclk, sda, sda_oe_n;
  logic [6:0]  saddr;                 // Serial address
  logic [1:0]  host_pin_config;                   // Host pin config
  int          errors = 0;            // Mismatches
  int          samples_checked = 0;   // Comparisons

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  ccr_regs #(.FRAME_DIV(64)) u_ccr_regs (.clk_i(clk_i), .reset_n_i(reset_n), .word_valid_i(wv),
    .word_i(w), .frame_sync_i(fsy), .dac_word_valid_i(dv), .dac_word_i(dw), .adc_ovf_i(adc_ovf),
    .dac_ovf_i(dac_ovf), .sda_ctl_o_i(sda_ctl), .sda_ctl_oe_n_i(sda_ctl_oe_n), .rd_data_o(rd),
    .rd_valid_o(rv), .continuous_transfer_select_o(cont), .recursive_filter_select_o(recf),
    .bias_level_select_o(bias), .analog_loop_enable_o(aloop), .digital_loop_enable_o(dloop),
    .full_width_dac_word_o(d16), .rate_filter_bypass_o(byp), .serial_address_o(saddr),
    .host_pin_config_o(host_pin_config), .sclk_o(sclk), .sda_o(sda), .sda_oe_n_o(sda_oe_n));

  ccr_host_model u_ccr_host_model (.clk_i(clk_i), .rd_valid_i(rv), .rd_data_i(rd), .word_valid_o(wv),
    .word_o(w), .frame_sync_o(fsy), .dac_word_valid_o(dv), .dac_word_o(dw));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [2:0] code, input logic [7:0] exp);
    u_ccr_host_model.read(code, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, exp);
  endtask : rchk

  task automatic do_reset();
    @(negedge clk_i);
    reset_n <= 1'b0;
    repeat (20) @(negedge clk_i);
    reset_n <= 1'b1;
    @(negedge clk_i);
  endtask : do_reset

  // Count bit clock rises over 128 master clocks
  task automatic rises(output int n);
    logic p;
    n = 0;
    p = sclk;
    repeat (128) begin
      @(negedge clk_i);
      if (sclk === 1'b1 && p === 1'b0) n++;
      p = sclk;
    end
  endtask : rises

  task automatic test_done();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h20);
    chk({1'b0, saddr}, 8'h45);
    chk({7'h0, sda_oe_n}, {7'h0, sda_ctl_oe_n});
  endtask : t_reset_values

  task automatic t_reg_one();
    u_ccr_host_model.send(3'h1, 1'b0, 8'hbf);
    chk({7'h0, bias}, 8'h00);
    u_ccr_host_model.fsync();
    rchk(3'h1, 8'h2f);
    chk({3'h0, cont, recf, bias, aloop, dloop}, 8'h0f);
    chk({7'h0, d16}, 8'h01);
    u_ccr_host_model.send(3'h1, 1'b0, 8'h00);
    u_ccr_host_model.fsync();
    chk({4'h0, recf, bias, aloop, dloop}, 8'h00);
  endtask : t_reg_one

  task automatic t_reg_two();
    // Normal pin drive differs from the spare value, so both paths are told apart
    sda_ctl      <= 1'b0;
    sda_ctl_oe_n <= 1'b1;
    u_ccr_host_model.send(3'h2, 1'b0, 8'h5e);
    u_ccr_host_model.fsync();
    rchk(3'h2, 8'h5e);
    chk({byp, saddr}, 8'hb5);
    chk({4'h0, host_pin_config, sda, sda_oe_n}, 8'h0a);
    u_ccr_host_model.send(3'h2, 1'b0, 8'h59);
    u_ccr_host_model.fsync();
    chk({6'h0, sda, sda_oe_n}, 8'h01);
    u_ccr_host_model.send(3'h2, 1'b0, 8'h20);
    u_ccr_host_model.fsync();
    sda_ctl      <= 1'b1;
    sda_ctl_oe_n <= 1'b0;
  endtask : t_reg_two

  task automatic t_overflow_unmapped();
    adc_ovf <= 1'b1;
    rchk(3'h1, 8'h80);
    adc_ovf <= 1'b0;
    dac_ovf <= 1'b1;
    rchk(3'h1, 8'h10);
    dac_ovf <= 1'b0;
    u_ccr_host_model.send(3'h3, 1'b0, 8'hff);
    u_ccr_host_model.send(3'h0, 1'b0, 8'hff);
    u_ccr_host_model.fsync();
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h20);
  endtask : t_overflow_unmapped

  task automatic t_sclk();
    int n;
    rises(n);
    chk(n[7:0], 8'h40);
    u_ccr_host_model.send(3'h2, 1'b0, 8'ha0);
    u_ccr_host_model.fsync();
    repeat (20) @(negedge clk_i);
    rises(n);
    chk(n[7:0], 8'h10);
    u_ccr_host_model.send(3'h2, 1'b0, 8'h20);
    u_ccr_host_model.fsync();
  endtask : t_sclk

  task automatic t_continuous();
    u_ccr_host_model.send(3'h1, 1'b0, 8'h40);
    u_ccr_host_model.fsync();
    chk({7'h0, cont}, 8'h01);
    u_ccr_host_model.read(3'h1, d, ok);
    chk({7'h0, ok}, 8'h00);
    u_ccr_host_model.dac(16'h1234);
    chk({7'h0, cont}, 8'h01);
    u_ccr_host_model.dac(16'h1235);
    chk({7'h0, cont}, 8'h00);
    u_ccr_host_model.send(3'h1, 1'b0, 8'h41);
    u_ccr_host_model.fsync();
    u_ccr_host_model.dac(16'h0001);
    chk({7'h0, cont}, 8'h01);
    do_reset();
    chk({7'h0, cont}, 8'h00);
    rchk(3'h1, 8'h00);
  endtask : t_continuous

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_i);
    reset_n <= 1'b1;
    @(negedge clk_i);
    t_reset_values();
    t_reg_one();
    t_reg_two();
    t_overflow_unmapped();
    t_sclk();
    t_continuous();
    test_done();
  end

  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
